// *** include/pcd_defines.svh ***
// command decoder constants: bytes, opcodes, register map, reset values
// assumes inclusion by bare name from design files
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH

// command bytes
`define PCD_PREFIX       8'h1d
`define PCD_OP_PAREN     8'h28
`define PCD_SUB_HEAD     8'h4b
`define PCD_SUB_MARK     8'h46
`define PCD_OP_SPEED     8'h45
`define PCD_OP_TEXTPOS   8'h48
`define PCD_OP_MARGIN    8'h4c
`define PCD_OP_LINE      8'h54
`define PCD_OP_CUT       8'h56
`define PCD_OP_FONT      8'h66

// parameter counts per command
`define PCD_N_HEAD       3'd4
`define PCD_N_MARK       3'd6
`define PCD_N_ONE        3'd1
`define PCD_N_TWO        3'd2

// parameter values
`define PCD_HEAD_LEN     8'h02
`define PCD_FN_ENERGIZE  8'h00
`define PCD_FN_DENSITY   8'h01
`define PCD_ENERGIZE_ONE 8'h01
`define PCD_ENERGIZE_TWO 8'h02
`define PCD_DENS_MIN     8'hf6
`define PCD_DENS_MAX     8'h0a
`define PCD_TEXT_OFF     8'h00
`define PCD_TEXT_BELOW   8'h02
`define PCD_LINE_DROP    8'h00
`define PCD_LINE_PRINT   8'h01
`define PCD_CUT_HERE     8'h01
`define PCD_CUT_FEED     8'h42
`define PCD_SPEED_LSB    4
`define PCD_SPEED_MSB    5

// distances in mm, and the factor from mm to 0.125 mm feed units
`define PCD_UNITS_PER_MM 16'd8
`define PCD_CUT_MM       16'd16
`define PCD_RETURN_MM    16'd118

// percent, speed and text scale figures
`define PCD_PCT_STD      8'd100
`define PCD_PCT_STEP     8'd5
`define PCD_MMPS_S1      8'd150
`define PCD_MMPS_S2      8'd100
`define PCD_MMPS_S3      8'd80
`define PCD_MMPS_S4      8'd50
`define PCD_TEXT_SCALE   4'h1

// register addresses
`define PCD_A_STATUS     4'h0
`define PCD_A_DENSITY    4'h1
`define PCD_A_MARGIN     4'h2
`define PCD_A_ADJ_PRINT  4'h3
`define PCD_A_ADJ_CUT    4'h4
`define PCD_A_CONTROL    4'h5

// reset values
`define PCD_RST_DENSITY  8'h00
`define PCD_RST_TEXTPOS  8'h02
`define PCD_RST_FONT     1'b1
`define PCD_RST_MARGIN   16'h0000
`define PCD_RST_ADJ      17'h00000
`endif

// *** include/pcd_pkg.sv ***
// types shared by the command decoder files
// assumes nothing beyond a SystemVerilog compiler
package pcd_pkg;
  // parser states, gray along idle -> opcode -> sub -> params
  typedef enum logic [1:0] {
    PCD_IDLE = 2'b00,
    PCD_OP   = 2'b01,
    PCD_SUB  = 2'b11,
    PCD_ARGS = 2'b10
  } pcd_state_e;

  typedef logic [1:0] pcd_speed_t;
  typedef logic [7:0] pcd_byte_t;
endpackage

// *** src/pcd_head_map.sv ***
// maps density step and speed level onto their physical figures
// assumes step within -10..+10, purely combinational
`timescale 1ns/100ps
`include "pcd_defines.svh"
module pcd_head_map (
  // settings in
  input  wire pcd_pkg::pcd_byte_t  density_step,
  input  wire pcd_pkg::pcd_speed_t speed_level,
  input  wire logic                two_part,
  // figures out
  output logic [7:0]               density_pct,
  output logic [7:0]               speed_mmps
);
  import pcd_pkg::*;

  // signed step of five percent around standard
  always_comb begin
    density_pct = 8'(`PCD_PCT_STD + 8'(density_step * `PCD_PCT_STEP));
  end

  // speed level to maximum speed, level 0 capped in two-part mode
  always_comb begin
    case (speed_level)
      2'h0:    speed_mmps = two_part ? `PCD_MMPS_S2 : `PCD_MMPS_S1;
      2'h1:    speed_mmps = `PCD_MMPS_S2;
      2'h2:    speed_mmps = `PCD_MMPS_S3;
      2'h3:    speed_mmps = `PCD_MMPS_S4;
      default: speed_mmps = `PCD_MMPS_S1;
    endcase
  end
endmodule

// *** src/pcd_cut_plan.sv ***
// works out feed before a cut and the return feed after it
// assumes count and adjustments already captured, combinational
`timescale 1ns/100ps
`include "pcd_defines.svh"
module pcd_cut_plan (
  // cut request
  input  wire pcd_pkg::pcd_byte_t mode,
  input  wire pcd_pkg::pcd_byte_t count,
  input  wire logic               mark_en,
  input  wire logic [16:0]        adj_cut,
  input  wire logic [16:0]        adj_print,
  // plan
  output logic [15:0]             pre_feed,
  output logic                    pre_to_mark,
  output logic                    pre_back,
  output logic [15:0]             ret_feed,
  output logic                    ret_to_mark,
  output logic                    ret_back
);
  import pcd_pkg::*;

  always_comb begin
    pre_feed    = 16'h0000;
    pre_to_mark = 1'b0;
    pre_back    = 1'b0;
    ret_feed    = 16'(`PCD_RETURN_MM * `PCD_UNITS_PER_MM);
    ret_to_mark = 1'b0;
    ret_back    = 1'b1;
    if (mode == `PCD_CUT_FEED) begin
      if (mark_en) begin
        // to the mark with stored offset, then to adjusted print start
        pre_feed    = adj_cut[15:0];
        pre_to_mark = 1'b1;
        pre_back    = adj_cut[16];
        ret_feed    = adj_print[15:0];
        ret_to_mark = 1'b1;
        ret_back    = adj_print[16];
      end else begin
        pre_feed = 16'(`PCD_CUT_MM * `PCD_UNITS_PER_MM) + {8'h00, count};
      end
    end
  end
endmodule

// *** src/pcd_top.sv ***
// command decoder for the receipt printer head and cutter settings
// assumes one byte per byte_valid pulse and line_start from the print engine
`timescale 1ns/100ps
`include "pcd_defines.svh"

module pcd_top (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst_b,
  // command bytes from the host port
  input  wire pcd_pkg::pcd_byte_t byte_data,
  input  wire logic               byte_valid,
  // print engine state
  input  wire logic               line_start,
  // register port
  input  wire logic [3:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  // head settings
  output logic [7:0]              density_step,
  output logic [7:0]              density_pct,
  output logic [1:0]              speed_level,
  output logic [7:0]              speed_mmps,
  output logic                    two_part,
  output logic [15:0]             left_margin,
  // bar code text settings
  output logic [7:0]              text_position,
  output logic                    text_font,
  output logic [3:0]              text_scale,
  // print buffer actions, one-cycle pulses
  output logic                    buffer_discard,
  output logic                    buffer_print,
  output logic                    line_home,
  // cut action, pulse plus plan
  output logic                    cut_go,
  output logic [15:0]             cut_pre_feed,
  output logic                    cut_pre_to_mark,
  output logic                    cut_pre_back,
  output logic [15:0]             cut_ret_feed,
  output logic                    cut_ret_to_mark,
  output logic                    cut_ret_back
);
  import pcd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    pcd_state_e      st;
    pcd_byte_t       op;
    pcd_byte_t       sub;
    logic [2:0]      cnt;
    logic [2:0]      need;
    logic [3:0][7:0] arg;
    pcd_byte_t       dens_pend;
    pcd_byte_t       dens;
    logic [7:0]      pct;
    pcd_speed_t      speed;
    logic [7:0]      mmps;
    logic            two_part;
    pcd_byte_t       textpos;
    logic            font;
    logic [15:0]     margin;
    logic [16:0]     adj_print;
    logic [16:0]     adj_cut;
    logic            mark_en;
    logic            discard;
    logic            print;
    logic            home;
    logic            cut;
    logic [15:0]     pre_feed;
    logic            pre_mark;
    logic            pre_back;
    logic [15:0]     ret_feed;
    logic            ret_mark;
    logic            ret_back;
    logic [31:0]     rdata;
  } pcd_state_s;

  pcd_state_s s_q;
  pcd_state_s s_d;

  // helpers: submodule outputs, the last-parameter flag and the parameters with the current byte
  logic [7:0]  map_pct;
  logic [7:0]  map_mmps;
  logic [15:0] plan_pre;
  logic        plan_pre_mark;
  logic        plan_pre_back;
  logic [15:0] plan_ret;
  logic        plan_ret_mark;
  logic        plan_ret_back;
  logic        last_arg;
  pcd_byte_t   a0;
  pcd_byte_t   a1;
  pcd_byte_t   a2;
  pcd_byte_t   a3;

  ////////////////////////////////////////////////////////////////////////////
  // figure lookup fed from next-state, cut plan from current state and byte; both outputs registered

  pcd_head_map u_map (
    .density_step (s_d.dens),
    .speed_level  (s_d.speed),
    .two_part     (s_d.two_part),
    .density_pct  (map_pct),
    .speed_mmps   (map_mmps)
  );

  pcd_cut_plan u_plan (
    .mode        (a0),
    .count       (a1),
    .mark_en     (s_q.mark_en),
    .adj_cut     (s_q.adj_cut),
    .adj_print   (s_q.adj_print),
    .pre_feed    (plan_pre),
    .pre_to_mark (plan_pre_mark),
    .pre_back    (plan_pre_back),
    .ret_feed    (plan_ret),
    .ret_to_mark (plan_ret_mark),
    .ret_back    (plan_ret_back)
  );

  // parameters as they stand with the current byte placed in
  always_comb begin
    a0 = (s_q.cnt == 3'd0) ? byte_data : s_q.arg[0];
    a1 = (s_q.cnt == 3'd1) ? byte_data : s_q.arg[1];
    a2 = (s_q.cnt == 3'd2) ? byte_data : s_q.arg[2];
    a3 = (s_q.cnt == 3'd3) ? byte_data : s_q.arg[3];
  end

  // last parameter arrives; cut mode 42 asks for one byte more
  always_comb begin
    last_arg = byte_valid && (s_q.st == PCD_ARGS) && (s_q.cnt + 3'd1 == s_q.need);
    if (s_q.op == `PCD_OP_CUT && s_q.cnt == 3'd0 && byte_data == `PCD_CUT_FEED) begin
      last_arg = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d         = s_q;
    s_d.discard = 1'b0;
    s_d.print   = 1'b0;
    s_d.home    = 1'b0;
    s_d.cut     = 1'b0;
    s_d.rdata   = 32'h00000000;

    // parser: prefix, opcode, optional sub-code, counted parameters
    if (byte_valid) begin
      case (s_q.st)
        PCD_IDLE: begin
          if (byte_data == `PCD_PREFIX) begin
            s_d.st = PCD_OP;
          end
        end
        PCD_OP: begin
          s_d.op  = byte_data;
          s_d.cnt = 3'd0;
          s_d.st  = PCD_ARGS;
          case (byte_data)
            `PCD_OP_PAREN:  s_d.st = PCD_SUB;
            `PCD_OP_MARGIN: s_d.need = `PCD_N_TWO;
            `PCD_OP_SPEED,
            `PCD_OP_TEXTPOS,
            `PCD_OP_LINE,
            `PCD_OP_CUT,
            `PCD_OP_FONT:   s_d.need = `PCD_N_ONE;
            default:        s_d.st = PCD_IDLE;
          endcase
        end
        PCD_SUB: begin
          s_d.sub = byte_data;
          s_d.st  = PCD_ARGS;
          case (byte_data)
            `PCD_SUB_HEAD: s_d.need = `PCD_N_HEAD;
            `PCD_SUB_MARK: s_d.need = `PCD_N_MARK; // swallowed here, set by software
            default:       s_d.st = PCD_IDLE;
          endcase
        end
        PCD_ARGS: begin
          if (s_q.cnt < 3'd4) begin
            s_d.arg[s_q.cnt[1:0]] = byte_data;
          end
          s_d.cnt = s_q.cnt + 3'd1;
          if (s_q.op == `PCD_OP_CUT && s_q.cnt == 3'd0 && byte_data == `PCD_CUT_FEED) begin
            s_d.need = `PCD_N_TWO;
          end
          if (last_arg) begin
            s_d.st = PCD_IDLE;
          end
        end
        default: s_d.st = PCD_IDLE;
      endcase
    end

    // command execution on the final parameter byte
    if (last_arg) begin
      case (s_q.op)
        `PCD_OP_PAREN: begin
          if (s_q.sub == `PCD_SUB_HEAD && a0 == `PCD_HEAD_LEN && a1 == 8'h00) begin
            if (a2 == `PCD_FN_DENSITY) begin
              // any byte is a signed step; host keeps it in F6..0A
              s_d.dens_pend = a3;
            end else if (a2 == `PCD_FN_ENERGIZE) begin
              if (a3 == `PCD_ENERGIZE_ONE) begin
                s_d.two_part = 1'b0;
              end else if (a3 == `PCD_ENERGIZE_TWO) begin
                s_d.two_part = 1'b1;
              end
            end
          end
        end
        `PCD_OP_SPEED: begin
          if (line_start) begin
            s_d.speed = a0[`PCD_SPEED_MSB:`PCD_SPEED_LSB];
            if (a0[`PCD_SPEED_MSB:`PCD_SPEED_LSB] == 2'h0) begin
              s_d.two_part = 1'b0;
            end
          end
        end
        `PCD_OP_TEXTPOS: begin
          if (a0 == `PCD_TEXT_OFF || a0 == `PCD_TEXT_BELOW) begin
            s_d.textpos = a0;
          end
        end
        `PCD_OP_FONT: begin
          s_d.font = a0[0];
        end
        `PCD_OP_MARGIN: begin
          if (line_start) begin
            s_d.margin = {a1, a0};
          end
        end
        `PCD_OP_LINE: begin
          if (a0 == `PCD_LINE_DROP) begin
            s_d.discard = 1'b1;
            s_d.home    = 1'b1;
          end else if (a0 == `PCD_LINE_PRINT) begin
            s_d.print = 1'b1;
            s_d.home  = 1'b1;
          end
        end
        `PCD_OP_CUT: begin
          if (line_start && (a0 == `PCD_CUT_HERE || a0 == `PCD_CUT_FEED)) begin
            s_d.cut      = 1'b1;
            s_d.pre_feed = plan_pre;
            s_d.pre_mark = plan_pre_mark;
            s_d.pre_back = plan_pre_back;
            s_d.ret_feed = plan_ret;
            s_d.ret_mark = plan_ret_mark;
            s_d.ret_back = plan_ret_back;
          end
        end
        default: s_d.st = PCD_IDLE;
      endcase
    end

    // the line in progress keeps one density; the latest is taken at line start
    if (line_start) begin
      s_d.dens = s_d.dens_pend;
    end

    // register writes steer the mark logic
    if (reg_wr) begin
      case (reg_addr)
        `PCD_A_ADJ_PRINT: s_d.adj_print = reg_wdata[16:0];
        `PCD_A_ADJ_CUT:   s_d.adj_cut   = reg_wdata[16:0];
        `PCD_A_CONTROL:   s_d.mark_en   = reg_wdata[0];
        default:          s_d.mark_en   = s_q.mark_en;
      endcase
    end

    // register reads, answer in the next cycle only
    if (reg_rd) begin
      case (reg_addr)
        `PCD_A_STATUS:    s_d.rdata = {24'h000000, s_q.textpos[1], s_q.font, s_q.two_part, s_q.speed,
                                       s_q.st, s_q.mark_en};
        `PCD_A_DENSITY:   s_d.rdata = {8'h00, s_q.dens_pend, s_q.pct, s_q.dens};
        `PCD_A_MARGIN:    s_d.rdata = {16'h0000, s_q.margin};
        `PCD_A_ADJ_PRINT: s_d.rdata = {15'h0000, s_q.adj_print};
        `PCD_A_ADJ_CUT:   s_d.rdata = {15'h0000, s_q.adj_cut};
        `PCD_A_CONTROL:   s_d.rdata = {31'h00000000, s_q.mark_en};
        default:          s_d.rdata = 32'h00000000;
      endcase
    end

    // registered figures
    s_d.pct  = map_pct;
    s_d.mmps = map_mmps;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register stage, synchronous active-low reset

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_q           <= '0;
      s_q.st        <= PCD_IDLE;
      s_q.dens_pend <= `PCD_RST_DENSITY;
      s_q.dens      <= `PCD_RST_DENSITY;
      s_q.pct       <= `PCD_PCT_STD;
      s_q.speed     <= 2'h0;
      s_q.mmps      <= `PCD_MMPS_S1;
      s_q.textpos   <= `PCD_RST_TEXTPOS;
      s_q.font      <= `PCD_RST_FONT;
      s_q.margin    <= `PCD_RST_MARGIN;
      s_q.adj_print <= `PCD_RST_ADJ;
      s_q.adj_cut   <= `PCD_RST_ADJ;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops, all but the constant text_scale

  assign reg_rdata       = s_q.rdata;
  assign density_step    = s_q.dens;
  assign density_pct     = s_q.pct;
  assign speed_level     = s_q.speed;
  assign speed_mmps      = s_q.mmps;
  assign two_part        = s_q.two_part;
  assign left_margin     = s_q.margin;
  assign text_position   = s_q.textpos;
  assign text_font       = s_q.font;
  assign text_scale      = `PCD_TEXT_SCALE;
  assign buffer_discard  = s_q.discard;
  assign buffer_print    = s_q.print;
  assign line_home       = s_q.home;
  assign cut_go          = s_q.cut;
  assign cut_pre_feed    = s_q.pre_feed;
  assign cut_pre_to_mark = s_q.pre_mark;
  assign cut_pre_back    = s_q.pre_back;
  assign cut_ret_feed    = s_q.ret_feed;
  assign cut_ret_to_mark = s_q.ret_mark;
  assign cut_ret_back    = s_q.ret_back;
endmodule

// *** test/pcd_top_sva.sv ***
// assertions on the command decoder ports
// assumes bind into pcd_top, one clock, synchronous reset rst_b
`timescale 1ns/100ps
module pcd_top_sva (
  // clock and reset
  input wire logic               clock,
  input wire logic               rst_b,
  // host side
  input wire pcd_pkg::pcd_byte_t byte_data,
  input wire logic               byte_valid,
  input wire logic               line_start,
  // settings
  input wire logic [7:0]         density_step,
  input wire logic [7:0]         density_pct,
  input wire logic [1:0]         speed_level,
  input wire logic [7:0]         speed_mmps,
  input wire logic               two_part,
  input wire logic [15:0]        left_margin,
  input wire logic [3:0]         text_scale,
  // actions
  input wire logic               buffer_discard,
  input wire logic               buffer_print,
  input wire logic               line_home,
  input wire logic               cut_go,
  input wire logic [15:0]        cut_pre_feed,
  input wire logic               cut_pre_to_mark,
  input wire logic               cut_pre_back,
  input wire logic [15:0]        cut_ret_feed,
  input wire logic               cut_ret_to_mark,
  input wire logic               cut_ret_back
);
  import pcd_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // settings against their causes
  property p_scale; text_scale == 4'h1; endproperty
  a_scale: assert property (p_scale) else $error("text scale not one");
  property p_pct; density_pct == 8'(8'h64 + density_step * 8'h05); endproperty
  a_pct: assert property (p_pct) else $error("density percent wrong");
  property p_mmps;
    speed_mmps == (speed_level == 2'h0 ? (two_part ? 8'h64 : 8'h96) :
                   speed_level == 2'h1 ? 8'h64 : speed_level == 2'h2 ? 8'h50 : 8'h32);
  endproperty
  a_mmps: assert property (p_mmps) else $error("speed figure wrong");
  property p_two; $rose(two_part) |-> $past(byte_valid) && $past(byte_data) == 8'h02; endproperty
  a_two: assert property (p_two) else $error("two-part without its command");
  property p_speed; $changed(speed_level) |-> $past(line_start) && $past(byte_valid); endproperty
  a_speed: assert property (p_speed) else $error("speed changed off line start");
  property p_marg;
    $changed(left_margin) |-> $past(line_start) && $past(byte_valid) && left_margin[15:8] == $past(byte_data);
  endproperty
  a_marg: assert property (p_marg) else $error("margin update wrong");
  property p_dens; $changed(density_step) |-> $past(line_start); endproperty
  a_dens: assert property (p_dens) else $error("density changed mid-line");
  ////////////////////////////////////////
  // actions
  property p_home; buffer_discard || buffer_print |-> line_home && !(buffer_discard && buffer_print); endproperty
  a_home: assert property (p_home) else $error("buffer action without home");
  property p_cut_ls; cut_go |-> $past(byte_valid) && $past(line_start); endproperty
  a_cut_ls: assert property (p_cut_ls) else $error("cut off line start");
  property p_cut_gap; cut_go |=> !cut_go [*2]; endproperty
  a_cut_gap: assert property (p_cut_gap) else $error("cut pulses too close");
  property p_ret; cut_go && !cut_ret_to_mark |-> cut_ret_feed == 16'h03b0 && cut_ret_back; endproperty
  a_ret: assert property (p_ret) else $error("return feed wrong");
  property p_pre;
    cut_go && !cut_pre_to_mark |-> !cut_pre_back &&
      (cut_pre_feed == 16'h0000 || cut_pre_feed == 16'h0080 + $past(byte_data));
  endproperty
  a_pre: assert property (p_pre) else $error("pre-cut feed wrong");
endmodule

bind pcd_top pcd_top_sva i_pcd_top_sva (.clock, .rst_b, .byte_data, .byte_valid, .line_start,
  .density_step, .density_pct, .speed_level, .speed_mmps, .two_part, .left_margin, .text_scale,
  .buffer_discard, .buffer_print, .line_home, .cut_go, .cut_pre_feed, .cut_pre_to_mark,
  .cut_pre_back, .cut_ret_feed, .cut_ret_to_mark, .cut_ret_back);

// *** test/pcd_host.sv ***
// host model that sends command bytes to the decoder
// assumes the bench calls send from its main process
`timescale 1ns/100ps
module pcd_host (
  // clock in
  input  wire logic           clock,
  // byte port out
  output pcd_pkg::pcd_byte_t byte_data,
  output logic               byte_valid
);
  import pcd_pkg::*;
  // idle at time zero
  initial begin
    byte_data = 8'h00;
    byte_valid = 1'b0;
  end
  // whole commands, gap idle cycles between bytes, data inverted when idle
  task automatic send(input pcd_byte_t q[$], input int gap);
    foreach (q[i]) begin
      @(posedge clock);
      byte_data <= q[i];
      byte_valid <= 1'b1;
      if (i < q.size() - 1) begin
        repeat (gap) begin
          @(posedge clock);
          byte_valid <= 1'b0;
          byte_data <= ~q[i];
        end
      end
    end
    @(posedge clock);
    byte_valid <= 1'b0;
    byte_data <= ~q[q.size() - 1];
  endtask
endmodule

// *** test/printer_head_cut_command_decoder_test.sv ***
// self-checking bench for the command decoder
// assumes pcd_top, pcd_host and the checker are compiled first
`timescale 1ns/100ps
module printer_head_cut_command_decoder_test;
  import pcd_pkg::*;
  typedef pcd_byte_t bq_t[$];
  logic        clock = 1'b0, rst_b = 1'b0, line_start = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, byte_valid;
  logic        two_part, text_font, buffer_discard, buffer_print, line_home, cut_go;
  logic        cut_pre_to_mark, cut_pre_back, cut_ret_to_mark, cut_ret_back;
  logic [3:0]  reg_addr = 4'h0, text_scale;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [7:0]  density_step, density_pct, speed_mmps, text_position, n8;
  logic [1:0]  speed_level;
  logic [15:0] left_margin, cut_pre_feed, cut_ret_feed, seed = 16'hda9d;
  logic [35:0] e_plan = 36'h0;
  pcd_byte_t   byte_data;
  int          errors = 0, n_checks = 0, e_step = 0, e_pend = 0, e_lvl = 0, e_two = 0;
  int          e_margin = 0, e_tpos = 2, e_font = 1, e_mark = 0;
  logic [7:0]  spd[4] = '{8'h96, 8'h64, 8'h50, 8'h32};

  pcd_top i_pcd_top (.clock, .rst_b, .byte_data, .byte_valid, .line_start, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .density_step, .density_pct, .speed_level, .speed_mmps, .two_part,
    .left_margin, .text_position, .text_font, .text_scale, .buffer_discard, .buffer_print, .line_home,
    .cut_go, .cut_pre_feed, .cut_pre_to_mark, .cut_pre_back, .cut_ret_feed, .cut_ret_to_mark, .cut_ret_back);
  pcd_host i_pcd_host (.clock, .byte_data, .byte_valid);

  // 100 ns clock
  always #50 clock = ~clock;
  ////////////////////////////////////////
  // helpers
  function automatic logic [7:0] rnd();
    seed = {1'b0, seed[15:1]} ^ (seed[0] ? 16'hb400 : 16'h0000);
    return seed[7:0];
  endfunction
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic model_check();
    check({density_step, density_pct, speed_level, speed_mmps, two_part, text_font, text_position, text_scale},
      {8'(e_step), 8'(100 + 5 * e_step), 2'(e_lvl), (e_lvl == 0 && e_two != 0) ? 8'h64 : spd[e_lvl],
       1'(e_two), 1'(e_font), 8'(e_tpos), 4'h1});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask
  task automatic run(input bq_t q, input int gap = 0);
    i_pcd_host.send(q, gap);
    #1;
  endtask
  task automatic dens(input int m, input int gap = 0);
    e_pend = m;
    run('{8'h1d, 8'h28, 8'h4b, 8'h02, 8'h00, 8'h01, 8'(m)}, gap);
    @(posedge clock);
    #1;
    if (line_start) e_step = e_pend;
    model_check();
  endtask
  task automatic speed(input int l);
    run('{8'h1d, 8'h45, (rnd() & 8'hcf) | 8'(l << 4)});
    if (line_start) e_lvl = l;
    if (line_start && l == 0) e_two = 0;
    model_check();
  endtask
  task automatic energ(input logic [7:0] m);
    run('{8'h1d, 8'h28, 8'h4b, 8'h02, 8'h00, 8'h00, m});
    if (m == 8'h01 || m == 8'h02) e_two = int'(m == 8'h02);
    model_check();
  endtask
  task automatic marg(input logic [7:0] lo, input logic [7:0] hi);
    run('{8'h1d, 8'h4c, lo, hi});
    if (line_start) e_margin = {hi, lo};
    rd(4'h2, 32'(e_margin));
  endtask
  task automatic cut(input bq_t q, input logic go, input logic [35:0] plan);
    run(q);
    if (go) e_plan = plan;
    check({cut_go, cut_pre_to_mark, cut_pre_back, cut_ret_to_mark, cut_ret_back, cut_pre_feed, cut_ret_feed},
      {go, e_plan});
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #2000000;
    errors++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1;
    model_check();
    rd(4'h3, 32'h0);
    for (int i = 0; i < 27; i++) dens(i < 21 ? i - 10 : int'(rnd()) % 21 - 10, i % 2);
    @(posedge clock);
    line_start <= 1'b0;
    dens(7);
    dens(-3);
    speed(3);
    marg(8'h12, 8'h34);
    cut('{8'h1d, 8'h56, 8'h01}, 1'b0, 36'h0);
    rd(4'h1, {8'h0, 8'(e_pend), 8'(100 + 5 * e_step), 8'(e_step)});
    @(posedge clock);
    line_start <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    e_step = e_pend;
    model_check();
    for (int l = 3; l >= 0; l--) speed(l);
    energ(8'h02);
    energ(8'h03);
    energ(8'h01);
    energ(8'h02);
    speed(0);
    for (int i = 0; i < 3; i++) begin
      run('{8'h1d, 8'h48, 8'(i)});
      run('{8'h1d, 8'h66, 8'(i & 1)});
      if (i != 1) e_tpos = i;
      e_font = i & 1;
      model_check();
    end
    marg(8'hff, 8'hff);
    for (int i = 0; i < 3; i++) marg(rnd(), rnd());
    for (int i = 0; i < 3; i++) begin
      run('{8'h1d, 8'h54, 8'(i)});
      check({buffer_discard, buffer_print, line_home}, {i == 0, i == 1, i < 2});
    end
    n8 = rnd();
    cut('{8'h1d, 8'h56, 8'h42, n8}, 1'b1, {4'h1, 16'h0080 + n8, 16'h03b0});
    cut('{8'h1d, 8'h56, 8'h42, 8'h00}, 1'b1, {4'h1, 16'h0080, 16'h03b0});
    cut('{8'h1d, 8'h56, 8'h01}, 1'b1, {4'h1, 16'h0000, 16'h03b0});
    cut('{8'h1d, 8'h56, 8'h03}, 1'b0, 36'h0);
    wr(4'h5, 32'h1);
    wr(4'h4, 32'h0001_0010);
    wr(4'h3, 32'h0000_0020);
    e_mark = 1;
    cut('{8'h1d, 8'h56, 8'h42, 8'h05}, 1'b1, {4'he, 16'h0010, 16'h0020});
    cut('{8'h1d, 8'h56, 8'h01}, 1'b1, {4'h1, 16'h0000, 16'h03b0});
    rd(4'h4, 32'h0001_0010);
    rd(4'h0, {24'h0, 1'(e_tpos >> 1), 1'(e_font), 1'(e_two), 2'(e_lvl), 2'b00, 1'(e_mark)});
    rd(4'h9, 32'h0);
    wr(4'h2, 32'hffff_ffff);
    rd(4'h2, 32'(e_margin));
    run('{8'h41, 8'h1d, 8'h99, 8'h1d, 8'h28, 8'h46, 8'h04, 8'h00, 8'h01, 8'h00, 8'h05, 8'h00});
    dens(4);
    run('{8'h1d, 8'h28, 8'h4b, 8'h03, 8'h00, 8'h01, 8'h05}, 2);
    model_check();
    rd(4'h3, 32'h0000_0020);
    finish_test();
  end
endmodule
